/* File: pciesb_consts.svh */
// Constants for the error reporting and power sideband block.
// Operation
// RULE1: Non-posted abort returns unsuccessful completion, no message.
// RULE2: Posted abort: no completion, non-fatal message if enabled.
// RULE3: User drives posted flag with the error.
// RULE4: Legacy locked abort returns locked unsuccessful completion.
// RULE5: Unsupported request: posted messages, non-posted completes.
// RULE6: Legacy locked unsupported request returns locked completion.
// RULE7: User flags unused-space non-posted reads as abort.
// RULE8: Checked ECRC mismatch sets status, messages if allowed.
// RULE9: User ECRC flag only when checking, AER off.
// RULE10: User drives header log with each error.
// RULE11: User holds header log until occupied shows.
// RULE12: Header log occupied until first-error bit cleared.
// RULE13: User stops completion errors while accept low.
// RULE14: L0s handled autonomously, nothing needed from user.
// RULE15: Programmed power state shown on two-bit output.
// RULE16: Non-D0 stalls new transmits, pending packets finish.
// RULE17: User sends no new requests outside D0.
// RULE18: L1 link packets exchanged without user involvement.
// RULE19: Wake request ignored when PME generation disabled.
// RULE20: Turn-off request held until user grants.
// RULE21: User finishes packets, then grants turn-off.
// RULE22: Turn-off acknowledge sent once grant seen.
// RULE23: After acknowledge all layers and interfaces close; code stops tx, completions, messages; APB and err_cpl_rdy stay open.
// RULE24: User pulses each error flag one cycle.
`ifndef PCIESB_CONSTS_SVH
`define PCIESB_CONSTS_SVH
`define PCIESB_ADDR_W        8
`define PCIESB_OFS_CTRL      8'h00
`define PCIESB_OFS_PMCTRL    8'h04
`define PCIESB_OFS_STATE     8'h08
`define PCIESB_OFS_ERRSTAT   8'h0C
`define PCIESB_OFS_HLOG0     8'h10
`define PCIESB_OFS_HLOG3     8'h1C
`define PCIESB_CTRL_MSG_EN   0
`define PCIESB_CTRL_ECRC_EN  1
`define PCIESB_CTRL_LEGACY   2
`define PCIESB_CTRL_AER_EN   3
`define PCIESB_CTRL_W        4
`define PCIESB_CTRL_RST      4'h0
`define PCIESB_PM_PME_EN     2
`define PCIESB_PM_RST        3'h0
`define PCIESB_PS_D0         2'h0
`define PCIESB_ES_ECRC       0
`define PCIESB_ES_UR         1
`define PCIESB_ES_CA         2
`define PCIESB_ES_FIRST      3
`define PCIESB_ES_W          4
`define PCIESB_CPL_HDR_W     48
`define PCIESB_HLOG_W        128
`endif

/* File: pciesb_pkg.sv */
// Types for the error reporting and power sideband block.
package pciesb_pkg;
	// Turn-off handshake states, Gray coded along the path.
	typedef enum logic [1:0] {
		TO_IDLE = 2'b00,
		TO_REQ  = 2'b01,
		TO_ACK  = 2'b11,
		TO_OFF  = 2'b10
	} pciesb_to_state_t;
endpackage : pciesb_pkg

/* File: pciesb_apb_slave.sv */
// APB slave front end with one wait state and an unmapped-address error.
`timescale 1ns/100ps
`include "pciesb_consts.svh"
module pciesb_apb_slave (
	input  wire logic                      pclk,    // Clock.
	input  wire logic                      presetn, // Asynchronous reset, active low.
	input  wire logic                      psel,    // Slave select.
	input  wire logic                      penable, // Access phase.
	input  wire logic                      pwrite,  // Write when high.
	input  wire logic [`PCIESB_ADDR_W-1:0] paddr,   // Byte address.
	input  wire logic [31:0]               rdata,   // Read value for paddr.
	input  wire logic                      mapped,  // Address is decoded.
	output logic                           pready,  // Transfer done.
	output logic [31:0]                    prdata,  // Read data.
	output logic                           pslverr, // Unmapped address.
	output logic                           wr_en    // Write takes effect now.
);
	logic        pready_q, pready_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pslverr_q, pslverr_d;

	// Answer in the second access cycle; read data is captured at the end of the first.
	always_comb begin
		pready_d  = psel & penable & ~pready_q;
		prdata_d  = prdata_q;
		pslverr_d = 1'b0;
		if (pready_d) begin
			prdata_d  = (mapped & ~pwrite) ? rdata : 32'h0000_0000;
			pslverr_d = ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= pready_d;
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign wr_en   = psel & penable & pready_q & pwrite & mapped;
endmodule : pciesb_apb_slave

/* File: pciesb_top.sv */
// Error reporting and programmed power management sideband logic.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "pciesb_consts.svh"
module pciesb_top (
	input  wire logic                         pclk,          // Clock, 250 MHz.
	input  wire logic                         presetn,       // Async reset, active low.
	input  wire logic                         psel,          // APB select.
	input  wire logic                         penable,       // APB enable.
	input  wire logic                         pwrite,        // APB write.
	input  wire logic [`PCIESB_ADDR_W-1:0]    paddr,         // APB address.
	input  wire logic [31:0]                  pwdata,        // APB write data.
	output logic                              pready,        // APB ready.
	output logic [31:0]                       prdata,        // APB read data.
	output logic                              pslverr,       // APB error.
	input  wire logic                         err_cpl_abort, // User completer abort.
	input  wire logic                         unsupported_request_flag, // User UR.
	input  wire logic                         err_ecrc,      // User ECRC error.
	input  wire logic                         err_posted,    // Errored request posted.
	input  wire logic                         err_locked_n,  // Low: request was locked.
	input  wire logic [`PCIESB_CPL_HDR_W-1:0] err_cpl_hdr,   // Request header info.
	input  wire logic [`PCIESB_HLOG_W-1:0]    err_hdr_log,   // Header for the log.
	input  wire logic                         rx_ecrc_bad,   // Checker saw bad ECRC.
	input  wire logic                         cpl_ack,       // Link took completion.
	input  wire logic                         turn_off_msg,  // Turn-off message seen.
	input  wire logic                         turnoff_ok,    // User grants turn-off.
	input  wire logic                         wake_request,  // User wake request.
	input  wire logic                         tx_valid,      // User transmit valid.
	input  wire logic                         tx_last,       // Last beat of packet.
	output logic                              err_cpl_rdy,   // Completion errors taken.
	output logic                              hdr_log_set,   // Header log occupied.
	output logic [1:0]                        power_state,   // Device power state.
	output logic                              pme_enable,    // PME generation on.
	output logic                              tx_ready,      // Transmit accepted.
	output logic                              turn_off_request, // Turn-off pending.
	output logic                              cpl_req,       // Completion to send.
	output logic                              cpl_locked,    // Completion is locked.
	output logic                              cpl_is_ur,     // UR status, else abort.
	output logic [`PCIESB_CPL_HDR_W-1:0]      cpl_hdr,       // Completion header info.
	output logic                              nonfatal_msg,  // Send non-fatal message.
	output logic                              pme_msg,       // Send PME message.
	output logic                              to_ack_msg,    // Send turn-off ack.
	output logic                              link_off       // Layers disabled.
);
	// Header log word index of a byte address.
	function automatic logic [2:0] hlog_word(input logic [`PCIESB_ADDR_W-1:0] a);
		hlog_word = a[4:2] - 3'h4;
	endfunction : hlog_word

	// True when the address hits a register of this block.
	function automatic logic reg_hit(input logic [`PCIESB_ADDR_W-1:0] a);
		reg_hit = (a[1:0] == 2'b00) && (a <= `PCIESB_OFS_HLOG3);
	endfunction : reg_hit

	logic        wr_en;
	logic [31:0] rdata;

	// Configuration registers written over APB, status bits and the header log.
	logic [`PCIESB_CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [2:0]                pm_q, pm_d;
	logic [`PCIESB_ES_W-1:0]   estat_q, estat_d;
	logic [`PCIESB_HLOG_W-1:0] hlog_q, hlog_d;
	logic                      hset_q, hset_d;

	// Completion path state.
	logic                         cpend_q, cpend_d;
	logic                         clock_q, clock_d;
	logic                         cur_q, cur_d;
	logic [`PCIESB_CPL_HDR_W-1:0] chdr_q, chdr_d;
	logic                         crdy_q, crdy_d;
	logic                         nf_q, nf_d;

	// Power management state.
	pciesb_pkg::pciesb_to_state_t to_q, to_d;
	logic tor_q, tor_d;
	logic ack_q, ack_d;
	logic off_q, off_d;
	logic wk_q, wk_d;
	logic pme_q, pme_d;
	logic inpkt_q, inpkt_d;
	logic txr_q, txr_d;

	logic msg_en, ecrc_en, legacy, aer_en;
	logic any_err, np_err, p_err, ecrc_evt;
	logic es_wr, es_clr_first;

	pciesb_apb_slave u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.rdata   (rdata),
		.mapped  (reg_hit(paddr)),
		.pready  (pready),
		.prdata  (prdata),
		.pslverr (pslverr),
		.wr_en   (wr_en)
	);

	assign msg_en  = ctrl_q[`PCIESB_CTRL_MSG_EN];
	assign ecrc_en = ctrl_q[`PCIESB_CTRL_ECRC_EN];
	assign legacy  = ctrl_q[`PCIESB_CTRL_LEGACY];
	assign aer_en  = ctrl_q[`PCIESB_CTRL_AER_EN];

	// Error events; a posted abort or UR never queues a completion.
	assign np_err   = (err_cpl_abort | unsupported_request_flag) & ~err_posted;
	assign p_err    = (err_cpl_abort | unsupported_request_flag) & err_posted;
	assign ecrc_evt = (rx_ecrc_bad & ecrc_en) | err_ecrc; // see RULE8
	assign any_err  = err_cpl_abort | unsupported_request_flag | ecrc_evt;
	assign es_wr    = wr_en && (paddr == `PCIESB_OFS_ERRSTAT);
	assign es_clr_first = es_wr & pwdata[`PCIESB_ES_FIRST];

	// Read data selection for the APB slave.
	always_comb begin
		rdata = 32'h0000_0000;
		case (paddr)
			`PCIESB_OFS_CTRL: begin
				rdata[`PCIESB_CTRL_W-1:0] = ctrl_q;
			end
			`PCIESB_OFS_PMCTRL: begin
				rdata[2:0] = pm_q;
			end
			`PCIESB_OFS_STATE: begin
				rdata[0] = hset_q;
				rdata[1] = tor_q;
				rdata[2] = off_q;
				rdata[3] = cpend_q;
				rdata[5:4] = to_q;
			end
			`PCIESB_OFS_ERRSTAT: begin
				rdata[`PCIESB_ES_W-1:0] = estat_q;
			end
			default: begin
				if (reg_hit(paddr)) begin
					rdata = hlog_q[32*hlog_word(paddr) +: 32];
				end
			end
		endcase
	end

	// Configuration registers, status bits and the header log.
	always_comb begin
		ctrl_d  = ctrl_q;
		pm_d    = pm_q;
		estat_d = estat_q;
		hlog_d  = hlog_q;
		hset_d  = hset_q;
		if (wr_en && (paddr == `PCIESB_OFS_CTRL)) begin
			ctrl_d = pwdata[`PCIESB_CTRL_W-1:0];
		end
		if (wr_en && (paddr == `PCIESB_OFS_PMCTRL)) begin
			pm_d = pwdata[2:0]; // see RULE15
		end
		// Status bits clear on a written one; a new event below wins.
		if (es_wr) begin
			estat_d = estat_q & ~pwdata[`PCIESB_ES_W-1:0];
		end
		if (es_clr_first) begin
			hset_d = 1'b0; // see RULE12
		end
		if (ecrc_evt) begin
			estat_d[`PCIESB_ES_ECRC] = 1'b1; // see RULE8
		end
		if (unsupported_request_flag) begin
			estat_d[`PCIESB_ES_UR] = 1'b1;
		end
		if (err_cpl_abort) begin
			estat_d[`PCIESB_ES_CA] = 1'b1;
		end
		// With AER on, the first error once the log is free, or in the cycle it frees, captures.
		if (any_err && aer_en && (!hset_q || es_clr_first)) begin
			hlog_d = err_hdr_log; // see RULE10
			hset_d = 1'b1; // see RULE12
			estat_d[`PCIESB_ES_FIRST] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= `PCIESB_CTRL_RST;
			pm_q    <= `PCIESB_PM_RST;
			estat_q <= '0;
			hlog_q  <= '0;
			hset_q  <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			pm_q    <= pm_d;
			estat_q <= estat_d;
			hlog_q  <= hlog_d;
			hset_q  <= hset_d;
		end
	end

	// Completion queue of one entry and error message generation.
	always_comb begin
		cpend_d = cpend_q;
		clock_d = clock_q;
		cur_d   = cur_q;
		chdr_d  = chdr_q;
		nf_d    = 1'b0;
		if (cpend_q && cpl_ack) begin
			cpend_d = 1'b0;
		end
		// A non-posted error while the entry is busy is dropped.
		if (np_err && !cpend_q && !off_q) begin
			cpend_d = 1'b1; // see RULE1, see RULE5
			clock_d = legacy & ~err_locked_n; // see RULE4, see RULE6
			cur_d   = unsupported_request_flag; // see RULE6
			chdr_d  = err_cpl_hdr;
		end
		// Posted errors and ECRC errors send a non-fatal message if enabled.
		if ((p_err || ecrc_evt) && msg_en && !off_q) begin
			nf_d = 1'b1; // see RULE2, see RULE5, see RULE8
		end
		crdy_d = ~cpend_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpend_q <= 1'b0;
			clock_q <= 1'b0;
			cur_q   <= 1'b0;
			chdr_q  <= '0;
			crdy_q  <= 1'b1;
			nf_q    <= 1'b0;
		end else begin
			cpend_q <= cpend_d;
			clock_q <= clock_d;
			cur_q   <= cur_d;
			chdr_q  <= chdr_d;
			crdy_q  <= crdy_d;
			nf_q    <= nf_d;
		end
	end

	// Turn-off handshake, wake requests and transmit stall.
	always_comb begin
		to_d    = to_q;
		tor_d   = tor_q;
		ack_d   = 1'b0;
		off_d   = off_q;
		pme_d   = 1'b0;
		wk_d    = wake_request;
		inpkt_d = inpkt_q;
		case (to_q)
			pciesb_pkg::TO_IDLE: begin
				if (turn_off_msg) begin
					to_d  = pciesb_pkg::TO_REQ;
					tor_d = 1'b1; // see RULE20
				end
			end
			pciesb_pkg::TO_REQ: begin
				if (turnoff_ok) begin
					to_d  = pciesb_pkg::TO_ACK;
					tor_d = 1'b0; // see RULE20
					ack_d = 1'b1; // see RULE22
				end
			end
			pciesb_pkg::TO_ACK: begin
				to_d  = pciesb_pkg::TO_OFF;
				off_d = 1'b1; // see RULE23
			end
			pciesb_pkg::TO_OFF: begin
				to_d = pciesb_pkg::TO_OFF;
			end
			default: begin
				to_d = pciesb_pkg::TO_IDLE;
			end
		endcase
		// A new wake request counts only outside D0 with PME enabled.
		if (wake_request && !wk_q && (pm_q[1:0] != `PCIESB_PS_D0)
		    && pm_q[`PCIESB_PM_PME_EN] && !off_q) begin
			pme_d = 1'b1; // see RULE19
		end
		// Track a packet already started so it is accepted to its end.
		if (tx_valid && txr_q) begin
			inpkt_d = ~tx_last;
		end
		txr_d = ~off_d & ((pm_q[1:0] == `PCIESB_PS_D0) | inpkt_d); // see RULE16
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_q    <= pciesb_pkg::TO_IDLE;
			tor_q   <= 1'b0;
			ack_q   <= 1'b0;
			off_q   <= 1'b0;
			wk_q    <= 1'b0;
			pme_q   <= 1'b0;
			inpkt_q <= 1'b0;
			txr_q   <= 1'b0;
		end else begin
			to_q    <= to_d;
			tor_q   <= tor_d;
			ack_q   <= ack_d;
			off_q   <= off_d;
			wk_q    <= wk_d;
			pme_q   <= pme_d;
			inpkt_q <= inpkt_d;
			txr_q   <= txr_d;
		end
	end

	// Link power states L0s and L1 are run by the link layer on its own;
	// this block only reports the programmed state. see RULE14, see RULE18
	assign power_state      = pm_q[1:0];
	assign pme_enable       = pm_q[`PCIESB_PM_PME_EN];
	assign err_cpl_rdy      = crdy_q;
	assign hdr_log_set      = hset_q;
	assign tx_ready         = txr_q;
	assign turn_off_request = tor_q;
	assign cpl_req          = cpend_q;
	assign cpl_locked       = clock_q;
	assign cpl_is_ur        = cur_q;
	assign cpl_hdr          = chdr_q;
	assign nonfatal_msg     = nf_q;
	assign pme_msg          = pme_q;
	assign to_ack_msg       = ack_q;
	assign link_off         = off_q;
endmodule : pciesb_top

/* File: pciesb_checker.sv */
// Port-level checker for the error and power sideband block.
`timescale 1ns/100ps
module pciesb_checker (
	input wire logic        pclk,                     // Clock.
	input wire logic        presetn,                  // Reset.
	input wire logic        err_cpl_abort,            // Abort flag.
	input wire logic        unsupported_request_flag, // UR flag.
	input wire logic        err_posted,               // Posted.
	input wire logic        err_cpl_rdy,              // Entry free.
	input wire logic        link_off,                 // Off.
	input wire logic        cpl_req,                  // Completion.
	input wire logic        cpl_is_ur,                // UR status.
	input wire logic        cpl_ack,                  // Taken.
	input wire logic [47:0] cpl_hdr,                  // Header.
	input wire logic        turn_off_request,         // Turn-off.
	input wire logic        turnoff_ok,               // Grant.
	input wire logic        to_ack_msg,               // Ack message.
	input wire logic        tx_ready,                 // Tx ready.
	input wire logic        tx_valid,                 // Tx valid.
	input wire logic        tx_last,                  // Last beat.
	input wire logic [1:0]  power_state,              // Power state.
	input wire logic        wake_request,             // Wake.
	input wire logic        pme_enable,               // PME on.
	input wire logic        pme_msg                   // PME sent.
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completion queueing, holding, the turn-off path, wake gating and transmit stall.
	abort_cpl_a: assert property (
		err_cpl_abort && !unsupported_request_flag && !err_posted && err_cpl_rdy && !link_off
		|=> cpl_req && !cpl_is_ur) else $error("abort gave no abort completion");
	ur_cpl_a: assert property (
		unsupported_request_flag && !err_posted && err_cpl_rdy && !link_off
		|=> cpl_req && cpl_is_ur) else $error("unsupported request gave no completion");
	cpl_hold_a: assert property (
		cpl_req && !cpl_ack |=> cpl_req && $stable(cpl_hdr)) else $error("completion not held");
	off_hold_a: assert property (
		turn_off_request && !turnoff_ok |=> turn_off_request) else $error("turn-off request lost");
	to_ack_a: assert property (
		turn_off_request && turnoff_ok |=> to_ack_msg && !turn_off_request ##1 link_off)
		else $error("turn-off acknowledge missing");
	off_quiet_a: assert property (
		link_off |-> !tx_ready && !turn_off_request) else $error("interface open after off");
	wake_gate_a: assert property (
		$rose(wake_request) && !pme_enable |=> !pme_msg [*2]) else $error("wake not ignored");
	tx_stall_a: assert property (
		tx_ready && tx_valid && tx_last && power_state != 2'h0 |=> !tx_ready)
		else $error("transmit not stalled");
	cover property ($rose(cpl_req));
	cover property (to_ack_msg);
	cover property ($rose(pme_msg));
endmodule : pciesb_checker

bind pciesb_top pciesb_checker chk (.*);

/* File: pciesb_user_model.sv */
// Behavioural model of the user logic that grants turn-off and takes completions.
`timescale 1ns/100ps
module pciesb_user_model (
	input  wire logic       pclk,             // Clock.
	input  wire logic       presetn,          // Reset, active low.
	input  wire logic [3:0] dly,              // Cycles before each answer.
	input  wire logic       turn_off_request, // Turn-off pending.
	input  wire logic       cpl_req,          // Completion waiting.
	output logic            turnoff_ok,       // Grant, held once given.
	output logic            cpl_ack           // Completion taken, one cycle.
);
	logic [3:0] cnt_q;
	logic       due;
	assign due = (cnt_q == dly);
	// Counts the answer delay, then grants or takes whatever waits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q      <= 4'h0;
			turnoff_ok <= 1'h0;
			cpl_ack    <= 1'h0;
		end else begin
			cpl_ack    <= cpl_req && !cpl_ack && due;
			turnoff_ok <= turnoff_ok || (turn_off_request && due);
			cnt_q      <= (due || !(cpl_req || turn_off_request)) ? 4'h0 : cnt_q + 4'h1;
		end
	end
endmodule : pciesb_user_model

/* File: pciesb_tb_top.sv */
// Self-checking bench for the error and power sideband block.
`timescale 1ns/100ps
`include "pciesb_consts.svh"
module pciesb_tb_top;
	localparam logic [127:0] H1 = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rv;
	logic         err_cpl_abort, unsupported_request_flag, err_ecrc, err_posted, err_locked_n;
	logic         rx_ecrc_bad, cpl_ack, turn_off_msg, turnoff_ok, wake_request, tx_valid, tx_last;
	logic         err_cpl_rdy, hdr_log_set, pme_enable, tx_ready, turn_off_request, cpl_req;
	logic         cpl_locked, cpl_is_ur, nonfatal_msg, pme_msg, to_ack_msg, link_off;
	logic [1:0]   power_state;
	logic [3:0]   dly;
	logic [47:0]  err_cpl_hdr, cpl_hdr;
	logic [127:0] err_hdr_log;
	int           n_mismatch, samples_checked, n_nf, n_pme, n_ack, n;

	pciesb_top uut (.*);
	pciesb_user_model partner (.*);

	// Clock of 4 ns.
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end

	// Counts the one-cycle message pulses.
	always @(posedge pclk) begin
		if (nonfatal_msg === 1'h1) n_nf++;
		if (pme_msg === 1'h1) n_pme++;
		if (to_ack_msg === 1'h1) n_ack++;
	end

	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic bail(input string what);
		n_mismatch++;
		$display("unexpected %s: expected 1, seen timeout", what);
		final_report();
	endtask : bail

	// One APB transfer; result lands in rv and re.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'h1 && i < 50);
		if (pready !== 1'h1) bail("pready");
		rv = prdata;
		re = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb

	// One-cycle error pulse; f is posted, ecrc, ur, abort. The log header is kept.
	task automatic err(input logic [3:0] f, input logic lkn, input logic [127:0] h);
		@(posedge pclk);
		{err_posted, err_ecrc, unsupported_request_flag, err_cpl_abort} <= f;
		{err_locked_n, err_cpl_hdr, err_hdr_log} <= {lkn, h[47:0], h};
		@(posedge pclk);
		{err_ecrc, unsupported_request_flag, err_cpl_abort} <= 3'h0;
		#1;
	endtask : err

	task automatic wait_rdy();
		for (int i = 0; i < 50 && err_cpl_rdy !== 1'h1; i++) begin
			@(posedge pclk);
			#1;
		end
		if (err_cpl_rdy !== 1'h1) bail("err_cpl_rdy");
	endtask : wait_rdy

	task automatic step();
		@(posedge pclk);
		#1;
	endtask : step

	task automatic wake();
		@(posedge pclk);
		wake_request <= 1'h1;
		repeat (3) @(posedge pclk);
		wake_request <= 1'h0;
		#1;
	endtask : wake

	task automatic t_reset();
		chk("tx_ready", 1'h1, tx_ready);
		chk("err_cpl_rdy", 1'h1, err_cpl_rdy);
		apb(1'h0, `PCIESB_OFS_PMCTRL, 32'h0000_0000);
		chk("pmctrl reset", 32'h0000_0000, rv);
		apb(1'h0, 8'h20, 32'h0000_0000);
		chk("unmapped error", 1'h1, re);
		$display("test reset done");
	endtask : t_reset

	task automatic t_abort();
		apb(1'h1, `PCIESB_OFS_CTRL, 32'h0000_000d);
		n = n_nf;
		err(4'h1, 1'h0, H1);
		chk("cpl_req", 1'h1, cpl_req);
		chk("cpl_locked", 1'h1, cpl_locked);
		chk("cpl_is_ur", 1'h0, cpl_is_ur);
		chk("cpl_hdr", H1[47:0], cpl_hdr);
		chk("err_cpl_rdy", 1'h0, err_cpl_rdy);
		chk("hdr_log_set", 1'h1, hdr_log_set);
		err(4'h2, 1'h1, ~H1);
		wait_rdy();
		chk("dropped entry", 1'h0, cpl_req);
		chk("abort message", n, n_nf);
		apb(1'h0, `PCIESB_OFS_HLOG0, 32'h0000_0000);
		chk("log word0", H1[31:0], rv);
		apb(1'h0, `PCIESB_OFS_HLOG3, 32'h0000_0000);
		chk("log word3", H1[127:96], rv);
		apb(1'h1, `PCIESB_OFS_ERRSTAT, 32'h0000_0008);
		step();
		chk("log cleared", 1'h0, hdr_log_set);
		$display("test abort done");
	endtask : t_abort

	task automatic t_ur();
		err(4'h2, 1'h1, H1);
		chk("cpl_is_ur", 1'h1, cpl_is_ur);
		chk("unlocked", 1'h0, cpl_locked);
		wait_rdy();
		err(4'h2, 1'h0, H1);
		chk("locked ur", 1'h1, cpl_locked);
		wait_rdy();
		n = n_nf;
		err(4'ha, 1'h1, H1);
		step();
		chk("posted ur message", n + 1, n_nf);
		chk("posted ur no cpl", 1'h0, cpl_req);
		err(4'h9, 1'h1, H1);
		step();
		chk("posted abort message", n + 2, n_nf);
		chk("posted abort no cpl", 1'h0, cpl_req);
		apb(1'h1, `PCIESB_OFS_CTRL, 32'h0000_000c);
		err(4'h9, 1'h1, H1);
		step();
		chk("message disabled", n + 2, n_nf);
		$display("test unsupported done");
	endtask : t_ur

	task automatic t_ecrc();
		apb(1'h1, `PCIESB_OFS_CTRL, 32'h0000_0003);
		n = n_nf;
		@(posedge pclk);
		rx_ecrc_bad <= 1'h1;
		@(posedge pclk);
		rx_ecrc_bad <= 1'h0;
		step();
		chk("ecrc message", n + 1, n_nf);
		apb(1'h0, `PCIESB_OFS_ERRSTAT, 32'h0000_0000);
		chk("ecrc status", 1'h1, rv[0]);
		apb(1'h1, `PCIESB_OFS_ERRSTAT, 32'h0000_000f);
		apb(1'h1, `PCIESB_OFS_CTRL, 32'h0000_0001);
		err(4'h4, 1'h1, H1);
		step();
		chk("user ecrc message", n + 2, n_nf);
		$display("test ecrc done");
	endtask : t_ecrc

	task automatic t_power();
		@(posedge pclk);
		tx_valid <= 1'h1;
		apb(1'h1, `PCIESB_OFS_PMCTRL, 32'h0000_0003);
		step();
		chk("power_state", 2'h3, power_state);
		chk("pending packet", 1'h1, tx_ready);
		@(posedge pclk);
		tx_last <= 1'h1;
		@(posedge pclk);
		{tx_valid, tx_last} <= 2'h0;
		step();
		step();
		chk("stalled", 1'h0, tx_ready);
		n = n_pme;
		wake();
		chk("wake ignored", n, n_pme);
		apb(1'h1, `PCIESB_OFS_PMCTRL, 32'h0000_0007);
		wake();
		chk("wake sent", n + 1, n_pme);
		chk("pme_enable", 1'h1, pme_enable);
		apb(1'h1, `PCIESB_OFS_PMCTRL, 32'h0000_0004);
		wake();
		chk("wake in D0", n + 1, n_pme);
		chk("ready in D0", 1'h1, tx_ready);
		$display("test power done");
	endtask : t_power

	task automatic t_off();
		@(posedge pclk);
		{turn_off_msg, dly} <= 5'h15;
		@(posedge pclk);
		turn_off_msg <= 1'h0;
		#1;
		chk("turn_off_request", 1'h1, turn_off_request);
		repeat (3) step();
		chk("request held", 1'h1, turn_off_request);
		chk("no early ack", 0, n_ack);
		for (int i = 0; i < 50 && n_ack == 0; i++) step();
		if (n_ack == 0) bail("to_ack_msg");
		chk("request dropped", 1'h0, turn_off_request);
		step();
		chk("link_off", 1'h1, link_off);
		chk("closed", 1'h0, tx_ready);
		err(4'h1, 1'h1, H1);
		chk("error after off", 1'h0, cpl_req);
		apb(1'h0, `PCIESB_OFS_STATE, 32'h0000_0000);
		chk("state word", 32'h0000_0024, rv);
		$display("test turn-off done");
	endtask : t_off

	// Reset, then every scenario in turn.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, rx_ecrc_bad, turn_off_msg} = '0;
		{err_cpl_abort, unsupported_request_flag, err_ecrc, err_posted, err_cpl_hdr} = '0;
		{err_hdr_log, wake_request, tx_valid, tx_last} = '0;
		err_locked_n = 1'h1;
		dly = 4'h2;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		step();
		t_reset();
		t_abort();
		t_ur();
		t_ecrc();
		t_power();
		t_off();
		final_report();
	end
endmodule : pciesb_tb_top
